// >>> msu_pkg.sv
// Shared constants for the serial port link and both of its ends
package msu_pkg;
  // ----------------------------------------
  // Control, status and pin bit positions
  // ----------------------------------------
  localparam int CTL_EN_BIT = 5;
  localparam int ST_BF_BIT = 0;
  localparam int ST_NACK_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_START_BIT = 3;
  localparam int ST_STOP_BIT = 4;
  localparam int DIR_SDO_BIT = 7;
  localparam int DIR_SCK_BIT = 6;
  localparam int PA_SS_BIT = 2;
  // ----------------------------------------
  // Mode field encodings
  // ----------------------------------------
  localparam logic [3:0] MODE_SPI = 4'h0;
  localparam logic [3:0] MODE_I2C_S7 = 4'h6;
  localparam logic [3:0] MODE_I2C_S10 = 4'h7;
  localparam logic [3:0] MODE_I2C_M = 4'h8;
  // ----------------------------------------
  // Reset values and fixed patterns
  // ----------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  // ----------------------------------------
  // Bit and cycle counts
  // ----------------------------------------
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int FILT_LEN = 3;
  localparam logic [1:0] SPI_HALF_LAST = 2'h3;
endpackage : msu_pkg

// >>> msu_link_if.sv
// Serial link pins between the serial port and its far party
`timescale 1ns/1ps
interface msu_link_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic miso;
  logic scl;
  logic sda;

  // Undriven data line idles high; I2C lines are wired-and with pull-up
  assign miso = miso_oe ? miso_o : 1'b1;
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport device (
    input sck, ss_n, mosi, scl, sda,
    output miso_o, miso_oe, dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe
  );
  modport host (
    output sck, ss_n, mosi, host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input miso, scl, sda
  );
endinterface : msu_link_if

// >>> msu_host.sv
// Far party: SPI master with divided clock and I2C line pullers
`timescale 1ns/1ps
module msu_host (
  input wire logic clk,
  input wire logic resetn,
  msu_link_if.host link,
  input wire logic spi_start,
  input wire logic [7:0] spi_tx,
  output logic spi_busy,
  output logic [7:0] spi_rx,
  output logic spi_done,
  input wire logic scl_pull,
  input wire logic sda_pull,
  output logic scl_level,
  output logic sda_level
);
  typedef enum logic {H_IDLE, H_XFER} msu_host_e;

  msu_host_e st_q;
  logic [1:0] div_q;
  logic sck_q, ss_q, mosi_q, pend_q, done_q;
  logic m1_q, m2_q, c1_q, c2_q, d1_q, d2_q, scl_pull_q, sda_pull_q;
  logic [7:0] tx_q, rx_sh_q, rx_q;
  logic [2:0] bit_q;
  logic edge_ev, rise_ev, fall_ev;

  // ----------------------------------------
  // Clock divider, free running
  // ----------------------------------------
  assign edge_ev = (div_q == msu_pkg::SPI_HALF_LAST);
  assign rise_ev = edge_ev & ~sck_q;
  assign fall_ev = edge_ev & sck_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q <= 2'h0;
      sck_q <= 1'b0; // [R10]
    end else begin
      div_q <= div_q + 2'h1;
      if (edge_ev) begin
        sck_q <= ~sck_q; // [R9]
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    m1_q <= link.miso;
    m2_q <= m1_q;
    c1_q <= link.scl;
    c2_q <= c1_q;
    d1_q <= link.sda;
    d2_q <= d1_q;
  end

  // ----------------------------------------
  // Byte transfer
  // ----------------------------------------
  assign spi_busy = pend_q | (st_q == H_XFER);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= H_IDLE;
      pend_q <= 1'b0;
      ss_q <= 1'b1;
      mosi_q <= 1'b1;
      tx_q <= 8'h00;
      rx_sh_q <= 8'h00;
      rx_q <= 8'h00;
      bit_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (spi_start && !spi_busy) begin
        pend_q <= 1'b1;
        tx_q <= spi_tx;
      end
      unique case (st_q)
        H_IDLE: begin
          if (pend_q && fall_ev) begin
            pend_q <= 1'b0;
            ss_q <= 1'b0;
            mosi_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            bit_q <= 3'h0;
            st_q <= H_XFER;
          end
        end
        H_XFER: begin
          if (rise_ev) begin
            rx_sh_q <= {rx_sh_q[6:0], m2_q}; // [R9]
          end else if (fall_ev) begin
            if (bit_q == msu_pkg::LAST_BIT) begin
              ss_q <= 1'b1;
              rx_q <= rx_sh_q;
              done_q <= 1'b1;
              st_q <= H_IDLE;
            end else begin
              mosi_q <= tx_q[7]; // [R9]
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // I2C line pullers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_pull_q <= 1'b0;
      sda_pull_q <= 1'b0;
    end else begin
      scl_pull_q <= scl_pull;
      sda_pull_q <= sda_pull;
    end
  end

  assign link.sck = sck_q;
  assign link.ss_n = ss_q;
  assign link.mosi = mosi_q;
  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe = scl_pull_q;
  assign link.host_sda_oe = sda_pull_q;
  assign spi_rx = rx_q;
  assign spi_done = done_q;
  assign scl_level = c2_q;
  assign sda_level = d2_q;
endmodule : msu_host

// >>> msu_device.sv
// Serial port end: SPI slave shifter on the link clock, I2C slave/master on clk
// Functional notes
// [R1] Buffer-full set when received byte reaches buffer
// [R2] Reading the buffer clears buffer-full
// [R3] Shifter only reachable through the buffer
// [R4] Software reads buffer before writing next byte
// [R5] Enable bit hands pins to serial function
// [R6] Reconfigure: clear enable, rewrite, set enable
// [R7] Software programs direction and select bits
// [R8] Opposite direction bit overrides pin function
// [R9] Master clocks; shift one edge, capture other
// [R10] Both ends use the same clock polarity
// [R11] I2C master/slave, general call, start/stop events
// [R12] Standard mode with 7-bit and 10-bit addressing
// [R13] Glitch filter on I2C input lines
// [R14] I2C mode takes clock and data pins itself
// [R15] Four-bit field selects the I2C mode
// [R16] Master bus clock is 4*(rate+1) clocks
// [R17] Software sets I2C pins as inputs first
// [R18] Interrupt request on transfer complete
// [R19] One byte per SPI transfer, copied after bit 8
`timescale 1ns/1ps
module msu_device (
  input wire logic clk,
  input wire logic resetn,
  msu_link_if.device link,
  input wire logic buf_wr,
  input wire logic buf_rd,
  input wire logic [7:0] wdata,
  input wire logic ctl_one_wr,
  input wire logic ctl_two_wr,
  input wire logic rate_wr,
  input wire logic [7:0] port_b_direction,
  input wire logic [7:0] port_a_latch,
  output logic [7:0] serial_buffer,
  output logic [7:0] serial_status_reg,
  output logic irq
);
  typedef enum logic [2:0] {I_IDLE, S_BITS, S_ACK, M_START, M_BITS, M_STOP} msu_i2c_e;

  logic [7:0] serial_control_one, serial_control_two, slave_address_or_rate, buf_q;
  logic bf_q, nack_q, start_q, stop_q, irq_q, spi_on_q, dn1_q, dn2_q, dn3_q;
  logic serial_port_enable, spi_on, i2c_on, i2c_master, spi_evt, i2c_rx_evt, m_done;
  logic [3:0] mode;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_control_one <= msu_pkg::CTL_RESET;
      serial_control_two <= msu_pkg::CTL_RESET;
      slave_address_or_rate <= msu_pkg::RATE_RESET;
    end else begin
      if (ctl_one_wr) begin
        serial_control_one <= wdata;
      end
      if (ctl_two_wr) begin
        serial_control_two <= wdata;
      end
      if (rate_wr) begin
        slave_address_or_rate <= wdata;
      end
    end
  end

  assign serial_port_enable = serial_control_one[msu_pkg::CTL_EN_BIT];
  assign mode = serial_control_one[3:0];
  // SCK must be input for slave, select bit set, else pin function is overridden
  assign spi_on = serial_port_enable & (mode == msu_pkg::MODE_SPI) // [R5]
    & port_b_direction[msu_pkg::DIR_SCK_BIT] & port_a_latch[msu_pkg::PA_SS_BIT]; // [R8]
  assign i2c_on = serial_port_enable & ((mode == msu_pkg::MODE_I2C_S7) // [R15]
    | (mode == msu_pkg::MODE_I2C_S10) | (mode == msu_pkg::MODE_I2C_M));
  assign i2c_master = mode == msu_pkg::MODE_I2C_M;

  // ----------------------------------------
  // SPI shifter on the link clock
  // ----------------------------------------
  logic rst_s1_q, rst_s2_q, in_q, act_q, tgl_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q, rx_q;

  always_ff @(posedge link.sck) begin
    rst_s1_q <= spi_on_q;
    rst_s2_q <= rst_s1_q;
    in_q <= link.mosi; // [R9]
    act_q <= rst_s2_q & ~link.ss_n;
  end

  always_ff @(negedge link.sck) begin
    if (!rst_s2_q) begin
      cnt_q <= 3'h0;
      sh_q <= msu_pkg::BUF_RESET;
      rx_q <= msu_pkg::BUF_RESET;
      tgl_q <= 1'b0;
    end else if (!act_q) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      // Buffer is stable during a byte; software waits for buffer-full
      sh_q <= (cnt_q == 3'h0) ? {buf_q[6:0], in_q} : {sh_q[6:0], in_q}; // [R9] [R4]
      if (cnt_q == msu_pkg::LAST_BIT) begin
        rx_q <= {sh_q[6:0], in_q}; // [R19]
        tgl_q <= ~tgl_q;
      end
    end
  end

  assign link.miso_o = (cnt_q == 3'h0) ? buf_q[7] : sh_q[7];
  // Select gates the driver directly so the first bit is valid before the first sck rise
  assign link.miso_oe = spi_on_q & ~port_b_direction[msu_pkg::DIR_SDO_BIT] & ~link.ss_n; // [R8] [R5]

  // ----------------------------------------
  // Crossings into clk
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      spi_on_q <= 1'b0;
    end else begin
      spi_on_q <= spi_on; // [R6]
    end
    dn1_q <= tgl_q;
    dn2_q <= dn1_q;
    dn3_q <= dn2_q;
  end

  assign spi_evt = spi_on_q & (dn2_q ^ dn3_q);

  // ----------------------------------------
  // I2C glitch filter
  // ----------------------------------------
  logic [1:0] lin_raw, lin_f, lin_p_q;
  logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;

  assign lin_raw = {link.sda, link.scl};

  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic s1_q, s2_q, f_q;
    logic [msu_pkg::FILT_LEN-1:0] hist_q;
    always_ff @(posedge clk) begin
      s1_q <= lin_raw[i];
      s2_q <= s1_q;
      if (!resetn) begin
        hist_q <= '1;
        f_q <= 1'b1;
      end else begin
        hist_q <= {hist_q[msu_pkg::FILT_LEN-2:0], s2_q};
        if (&hist_q) begin
          f_q <= 1'b1; // [R13]
        end else if (~|hist_q) begin
          f_q <= 1'b0; // [R13]
        end
      end
    end
    assign lin_f[i] = f_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lin_p_q <= 2'h3;
    end else begin
      lin_p_q <= lin_f;
    end
  end

  assign scl_f = lin_f[0];
  assign sda_f = lin_f[1];
  assign scl_rise = scl_f & ~lin_p_q[0];
  assign scl_fall = ~scl_f & lin_p_q[0];
  assign start_det = i2c_on & scl_f & lin_p_q[0] & lin_p_q[1] & ~sda_f; // [R11]
  assign stop_det = i2c_on & scl_f & lin_p_q[0] & ~lin_p_q[1] & sda_f; // [R11]

  // ----------------------------------------
  // I2C slave and master engine
  // ----------------------------------------
  msu_i2c_e st_q;
  logic [7:0] ish_q, tick_q;
  logic [3:0] bit_q;
  logic [1:0] stage_q, ph_q;
  logic scl_pull_q, sda_pull_q, tick, hit7, hit10a, hit10b, byte_end;

  assign tick = tick_q == slave_address_or_rate;
  assign hit7 = ((ish_q[7:1] == slave_address_or_rate[7:1]) & ~ish_q[0]) | (ish_q == msu_pkg::GEN_CALL); // [R11]
  assign hit10a = (ish_q[7:3] == msu_pkg::TEN_BIT_HDR) & (ish_q[2:1] == serial_control_two[1:0]) & ~ish_q[0];
  assign hit10b = ish_q == slave_address_or_rate;
  assign byte_end = (st_q == S_BITS) & scl_fall & (bit_q == msu_pkg::ACK_BIT);
  assign i2c_rx_evt = byte_end & (stage_q == 2'h2);
  assign m_done = (st_q == M_STOP) & tick & (ph_q == 2'h3);

  always_ff @(posedge clk) begin
    if (!resetn || !i2c_on || (st_q == I_IDLE) || !i2c_master || tick) begin
      tick_q <= 8'h00;
    end else begin
      tick_q <= tick_q + 8'h01; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !i2c_on) begin
      st_q <= I_IDLE;
      ish_q <= 8'h00;
      bit_q <= 4'h0;
      stage_q <= 2'h0;
      ph_q <= 2'h0;
      scl_pull_q <= 1'b0;
      sda_pull_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (i2c_master) begin
      unique case (st_q)
        I_IDLE: begin
          if (buf_wr) begin
            ish_q <= wdata;
            sda_pull_q <= 1'b1;
            st_q <= M_START;
          end
        end
        M_START: begin
          if (tick) begin
            scl_pull_q <= 1'b1;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            st_q <= M_BITS;
          end
        end
        M_BITS: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1; // [R16]
            unique case (ph_q)
              2'h0: sda_pull_q <= (bit_q == msu_pkg::ACK_BIT) ? 1'b0 : ~ish_q[7];
              2'h1: scl_pull_q <= 1'b0;
              2'h2: if (bit_q == msu_pkg::ACK_BIT) nack_q <= sda_f;
              2'h3: begin
                scl_pull_q <= 1'b1;
                ish_q <= {ish_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
                if (bit_q == msu_pkg::ACK_BIT) begin
                  st_q <= M_STOP;
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: sda_pull_q <= 1'b1;
              2'h1: scl_pull_q <= 1'b0;
              2'h2: sda_pull_q <= 1'b0;
              2'h3: st_q <= I_IDLE;
            endcase
          end
        end
        default: st_q <= I_IDLE;
      endcase
    end else if (start_det) begin
      st_q <= S_BITS;
      bit_q <= 4'h0;
      stage_q <= 2'h0;
      sda_pull_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= I_IDLE;
      sda_pull_q <= 1'b0;
    end else if (st_q == S_BITS) begin
      if (scl_rise && bit_q != msu_pkg::ACK_BIT) begin
        ish_q <= {ish_q[6:0], sda_f};
        bit_q <= bit_q + 4'h1;
      end else if (byte_end) begin
        // Ack when addressed; unaddressed frames are ignored until next start
        st_q <= S_ACK;
        sda_pull_q <= 1'b1;
        unique case (stage_q)
          2'h0: begin
            if (mode == msu_pkg::MODE_I2C_S7 && hit7) begin
              stage_q <= 2'h2; // [R12]
            end else if (mode == msu_pkg::MODE_I2C_S10 && hit10a) begin
              stage_q <= 2'h1; // [R12]
            end else begin
              st_q <= I_IDLE;
              sda_pull_q <= 1'b0;
            end
          end
          2'h1: begin
            if (hit10b) begin
              stage_q <= 2'h2; // [R12]
            end else begin
              st_q <= I_IDLE;
              sda_pull_q <= 1'b0;
            end
          end
          default: stage_q <= 2'h2;
        endcase
      end
    end else if (st_q == S_ACK && scl_fall) begin
      sda_pull_q <= 1'b0;
      bit_q <= 4'h0;
      st_q <= S_BITS;
    end
  end

  assign link.dev_scl_o = 1'b0;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_scl_oe = scl_pull_q; // [R14]
  assign link.dev_sda_oe = sda_pull_q; // [R14]

  // ----------------------------------------
  // Buffer, status and interrupt request
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      buf_q <= msu_pkg::BUF_RESET;
      bf_q <= 1'b0;
    end else begin
      if (spi_evt) begin
        buf_q <= rx_q; // [R19]
      end else if (i2c_rx_evt) begin
        buf_q <= ish_q;
      end else if (buf_wr) begin
        buf_q <= wdata; // [R3]
      end
      if (spi_evt || i2c_rx_evt) begin
        bf_q <= 1'b1; // [R1]
      end else if (buf_rd) begin
        bf_q <= 1'b0; // [R2]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !i2c_on) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (start_det) begin
      start_q <= 1'b1; // [R11]
      stop_q <= 1'b0;
    end else if (stop_det) begin
      start_q <= 1'b0;
      stop_q <= 1'b1; // [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= spi_evt | i2c_rx_evt | m_done | start_det | stop_det; // [R18] [R11]
    end
  end

  assign serial_buffer = buf_q; // [R3]
  assign serial_status_reg = {3'h0, stop_q, start_q, i2c_master & (st_q != I_IDLE), nack_q, bf_q};
  assign irq = irq_q;
endmodule : msu_device

// >>> msu_link_chk.sv
// Timing checks on the serial link pins between the two ends
`timescale 1ns/1ps
module msu_link_chk #(
  parameter int SCL_PERIOD = 40
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [7:0] gap_q;

  // ----------------------------------------
  // Span counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || ss_n) begin
      low_q <= 8'h00;
    end else if (low_q != 8'hff) begin
      low_q <= low_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !ss_n) begin
      high_q <= 8'h00;
    end else if (high_q != 8'hff) begin
      high_q <= high_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gap_q <= 8'hff;
    end else if ($rose(dev_scl_oe)) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_sck_high_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high phase is not four clocks");
  a_select_on_low: assert property ($changed(ss_n) |-> !sck)
    else $error("select changed while sck high");
  a_mosi_on_low: assert property ($changed(mosi) |-> !sck)
    else $error("mosi changed while sck high");
  a_miso_shift_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
    else $error("miso changed while sck high");
  a_frame_one_byte: assert property ($rose(ss_n) |-> low_q == 8'h40)
    else $error("select low span is not eight sck periods");
  a_miso_idle_off: assert property (ss_n && high_q > 8'h28 |-> !miso_oe)
    else $error("miso driven while deselected");
  a_scl_bit_period: assert property ($rose(dev_scl_oe) && gap_q < 8'h3c |-> gap_q == 8'(SCL_PERIOD - 1))
    else $error("master bit period wrong");
  a_scl_low_bound: assert property ($rose(dev_scl_oe) |-> ##[1:40] !dev_scl_oe)
    else $error("master scl low phase too long");
  a_sda_pull_bound: assert property ($rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
    else $error("device holds sda low too long");

  c_spi_frame: cover property ($rose(ss_n));
  c_master_clock: cover property ($rose(dev_scl_oe) && gap_q < 8'h3c);
  c_device_sda: cover property ($rose(dev_sda_oe) && !dev_scl_oe);
endmodule : msu_link_chk

// >>> sync_serial_port_spi_i2c_tb_top.sv
// Testbench joining the host end and the device end over the serial link
`timescale 1ns/1ps
module sync_serial_port_spi_i2c_tb_top;
  logic clk, resetn, buf_wr, buf_rd, ctl_one_wr, ctl_two_wr, rate_wr, irq;
  logic spi_start, spi_busy, spi_done, scl_pull, sda_pull, scl_level, sda_level;
  logic [7:0] wdata, port_b_direction, port_a_latch, serial_buffer, serial_status_reg, spi_tx, spi_rx;
  int miscompares, compares, b;
  int irq_cnt = 0;
  logic [7:0] dev_tx [3] = '{8'ha5, 8'h5a, 8'h00};
  logic [7:0] host_tx [3] = '{8'h3c, 8'hc3, 8'hff};

  msu_link_if link ();
  msu_device msu_device_i (.clk(clk), .resetn(resetn), .link(link), .buf_wr(buf_wr), .buf_rd(buf_rd),
    .wdata(wdata), .ctl_one_wr(ctl_one_wr), .ctl_two_wr(ctl_two_wr), .rate_wr(rate_wr),
    .port_b_direction(port_b_direction), .port_a_latch(port_a_latch), .serial_buffer(serial_buffer),
    .serial_status_reg(serial_status_reg), .irq(irq));
  msu_host msu_host_i (.clk(clk), .resetn(resetn), .link(link), .spi_start(spi_start), .spi_tx(spi_tx),
    .spi_busy(spi_busy), .spi_rx(spi_rx), .spi_done(spi_done), .scl_pull(scl_pull), .sda_pull(sda_pull),
    .scl_level(scl_level), .sda_level(sda_level));
  msu_link_chk #(.SCL_PERIOD(40)) msu_link_chk_i (.clk(clk), .resetn(resetn), .sck(link.sck),
    .ss_n(link.ss_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
    .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (irq === 1'b1)
      irq_cnt++;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  function automatic logic [7:0] ctl(input logic [3:0] m);
    ctl = 8'h00;
    ctl[msu_pkg::CTL_EN_BIT] = 1'b1;
    ctl[3:0] = m;
  endfunction : ctl

  // Select 0 buffer, 1 control one, 2 control two, 3 rate
  task automatic wr(input int sel, input logic [7:0] d);
    wdata = d;
    {buf_wr, ctl_one_wr, ctl_two_wr, rate_wr} = {sel == 0, sel == 1, sel == 2, sel == 3};
    cyc(1);
    {buf_wr, ctl_one_wr, ctl_two_wr, rate_wr} = 4'h0;
    cyc(1);
  endtask : wr

  // Enable, then let the link side leave reset
  task automatic en(input logic [3:0] m);
    wr(1, ctl(m));
    cyc(40);
  endtask : en

  task automatic rd_buf(input logic [7:0] exp);
    chk8(serial_buffer, exp);
    buf_rd = 1'b1;
    cyc(1);
    buf_rd = 1'b0;
    chk8({7'h00, serial_status_reg[msu_pkg::ST_BF_BIT]}, 8'h00);
  endtask : rd_buf

  task automatic wait_st(input int bit_i, input logic v, input int lim);
    for (int n = 0; n < lim && serial_status_reg[bit_i] !== v; n++)
      cyc(1);
  endtask : wait_st

  task automatic spi_xfer(input logic [7:0] tx, input logic [7:0] exp);
    spi_tx = tx;
    spi_start = 1'b1;
    cyc(1);
    spi_start = 1'b0;
    for (int n = 0; n < 200 && spi_done !== 1'b1; n++)
      cyc(1);
    chk8(spi_rx, exp);
    wait_st(msu_pkg::ST_BF_BIT, 1'b1, 60);
    cyc(2);
  endtask : spi_xfer

  task automatic i2c_bit(input logic v, output logic got);
    sda_pull = ~v;
    cyc(10);
    scl_pull = 1'b0;
    cyc(10);
    got = sda_level;
    cyc(10);
    scl_pull = 1'b1;
    cyc(10);
  endtask : i2c_bit

  // Start, two bytes with ack slots, stop; compares the ack pattern
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [1:0] ex);
    logic [1:0] ack;
    logic g;
    sda_pull = 1'b1;
    cyc(20);
    scl_pull = 1'b1;
    for (int k = 0; k < 2; k++) begin
      for (int i = 7; i >= 0; i--)
        i2c_bit(k ? b1[i] : b0[i], g);
      i2c_bit(1'b1, g);
      ack[k] = ~g;
    end
    sda_pull = 1'b1;
    cyc(10);
    scl_pull = 1'b0;
    cyc(20);
    sda_pull = 1'b0;
    cyc(20);
    chk8({6'h00, ack}, {6'h00, ex});
  endtask : frame

  task automatic ack_once();
    repeat (9) @(negedge scl_level);
    #2;
    sda_pull = 1'b1;
    @(posedge scl_level);
    for (int n = 0; n < 30 && scl_level === 1'b1; n++)
      cyc(1);
    sda_pull = 1'b0;
  endtask : ack_once

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {buf_wr, buf_rd, ctl_one_wr, ctl_two_wr, rate_wr, spi_start, scl_pull, sda_pull} = 8'h00;
    {wdata, spi_tx, port_b_direction, port_a_latch} = {8'h00, 8'h00, 8'hff, 8'h00};
    miscompares = 0;
    compares = 0;
    resetn = 1'b0;
    cyc(16);
    resetn = 1'b1;
    cyc(1);
    chk8(serial_buffer, msu_pkg::BUF_RESET);
    chk8(serial_status_reg, 8'h00);
    {port_b_direction, port_a_latch} = {8'h40, 8'h04};
    // Link side needs sck edges with enable low to load its reset values
    cyc(24);
    en(msu_pkg::MODE_SPI);
    for (int i = 0; i < 3; i++) begin
      wr(0, dev_tx[i]);
      chk8(serial_buffer, dev_tx[i]);
      b = irq_cnt;
      spi_xfer(host_tx[i], dev_tx[i]);
      chk8(serial_status_reg, 8'h01);
      chk8(8'(irq_cnt - b), 8'h01);
      rd_buf(host_tx[i]);
    end
    port_b_direction = 8'hc0;
    spi_xfer(8'h66, 8'hff);
    rd_buf(8'h66);
    port_b_direction = 8'h40;
    wr(1, 8'h00);
    spi_xfer(8'h77, 8'hff);
    chk8(serial_status_reg, 8'h00);
    en(msu_pkg::MODE_SPI);
    wr(0, 8'h11);
    spi_xfer(8'h22, 8'h11);
    rd_buf(8'h22);
    wr(1, 8'h00);
    port_b_direction = 8'hff;
    wr(3, 8'h09);
    en(msu_pkg::MODE_I2C_M);
    b = irq_cnt;
    wr(0, 8'ha0);
    wait_st(msu_pkg::ST_BUSY_BIT, 1'b0, 1000);
    cyc(10);
    chk8({6'h00, serial_status_reg[msu_pkg::ST_STOP_BIT], serial_status_reg[msu_pkg::ST_NACK_BIT]}, 8'h03);
    chk8({7'h00, irq_cnt > b}, 8'h01);
    fork
      ack_once();
    join_none
    wr(0, 8'h5c);
    wait_st(msu_pkg::ST_BUSY_BIT, 1'b0, 1000);
    cyc(10);
    chk8({6'h00, serial_status_reg[msu_pkg::ST_STOP_BIT], serial_status_reg[msu_pkg::ST_NACK_BIT]}, 8'h02);
    wr(1, 8'h00);
    wr(3, 8'h84);
    en(msu_pkg::MODE_I2C_S7);
    b = irq_cnt;
    sda_pull = 1'b1;
    cyc(1);
    sda_pull = 1'b0;
    cyc(20);
    chk8(8'(irq_cnt - b), 8'h00);
    frame(8'h84, 8'h99, 2'b11);
    chk8({6'h00, serial_status_reg[msu_pkg::ST_STOP_BIT], serial_status_reg[msu_pkg::ST_BF_BIT]}, 8'h03);
    rd_buf(8'h99);
    frame(8'h85, 8'h77, 2'b00);
    frame(8'h88, 8'h77, 2'b00);
    frame(8'h00, 8'h5e, 2'b11);
    rd_buf(8'h5e);
    wr(2, 8'h02);
    wr(1, 8'h00);
    en(msu_pkg::MODE_I2C_S10);
    frame(8'hf4, 8'h84, 2'b11);
    frame(8'hf0, 8'h84, 2'b00);
    stop_test();
  end
endmodule : sync_serial_port_spi_i2c_tb_top
